// ===== srs_decode.sv
// Option code decoder: one code and its table to a stopping reaction
module srs_decode (
  // Code and table selection
  input  wire logic [15:0]       code,
  input  wire srs_pkg::srs_kind_t kind,
  // Decoded reaction
  output srs_pkg::srs_act_t      act
);

  // ----------------------------------------------------------------
  // Table lookup; anything not listed stays invalid
  // ----------------------------------------------------------------
  always_comb begin
    act = '{valid: 1'b0, ramp: srs_pkg::SRS_RAMP_NONE, to_sod: 1'b0};
    case (kind)
      srs_pkg::SRS_KIND_QS: begin
        // Both ramps end in switch-on-disabled
        if (code == srs_pkg::CODE_IMMEDIATE) begin
          act = '{1'b1, srs_pkg::SRS_RAMP_IMM, 1'b0};
        end else if (code == srs_pkg::CODE_SLOW) begin
          act = '{1'b1, srs_pkg::SRS_RAMP_SLOW, 1'b1};
        end else if (code == srs_pkg::CODE_QUICK) begin
          act = '{1'b1, srs_pkg::SRS_RAMP_QUICK, 1'b1};
        end
      end
      srs_pkg::SRS_KIND_SHUT, srs_pkg::SRS_KIND_DIS: begin
        // Shutdown and disable share one table
        if (code == srs_pkg::CODE_IMMEDIATE) begin
          act = '{1'b1, srs_pkg::SRS_RAMP_IMM, 1'b0};
        end else if (code == srs_pkg::CODE_SLOW) begin
          act = '{1'b1, srs_pkg::SRS_RAMP_SLOW, 1'b1};
        end
      end
      srs_pkg::SRS_KIND_HALT: begin
        // Zero is reserved here, unlike the other tables
        if (code == srs_pkg::CODE_SLOW) begin
          act = '{1'b1, srs_pkg::SRS_RAMP_SLOW, 1'b0};
        end else if (code == srs_pkg::CODE_QUICK) begin
          act = '{1'b1, srs_pkg::SRS_RAMP_QUICK, 1'b0};
        end
      end
      srs_pkg::SRS_KIND_FAULT: begin
        // Fault never forces a state change by itself
        if (code == srs_pkg::CODE_IMMEDIATE) begin
          act = '{1'b1, srs_pkg::SRS_RAMP_IMM, 1'b0};
        end else if (code == srs_pkg::CODE_SLOW) begin
          act = '{1'b1, srs_pkg::SRS_RAMP_SLOW, 1'b0};
        end else if (code == srs_pkg::CODE_QUICK) begin
          act = '{1'b1, srs_pkg::SRS_RAMP_QUICK, 1'b0};
        end
      end
      default: begin
        act = '{1'b0, srs_pkg::SRS_RAMP_NONE, 1'b0};
      end
    endcase
  end

endmodule

// ===== srs_master.sv
// Fieldbus master model that writes and reads the option code objects
module srs_master (
  // Clock
  input  wire logic                 clk_sys,
  // Object dictionary access
  output srs_pkg::srs_od_req_t      od_req,
  input  wire srs_pkg::srs_od_rsp_t od_rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle from time zero so no access is seen during reset
  initial od_req = '0;

  // ----------------------------------------------------------------
  // One access: request for a single cycle, answer one edge later
  // ----------------------------------------------------------------
  // Only the bench decides when a reserved value goes out
  task automatic access(input  logic                 w,
                        input  logic [15:0]          idx,
                        input  logic [15:0]          d,
                        output srs_pkg::srs_od_rsp_t rsp);
    @(posedge clk_sys);
    od_req <= '{wr: w, rd: !w, index: idx, wdata: d};
    @(posedge clk_sys);
    // Released lines show the inverse, so stale data never looks live
    od_req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~d};
    @(posedge clk_sys);
    // Answer pulse lasts one cycle, so it is taken at this edge
    rsp = od_rsp;
  endtask
endmodule

// ===== srs_pkg.sv
// Constants, types and carriers shared by the stop reaction selector
package srs_pkg;

  // ----------------------------------------------------------------
  // Object dictionary indices of the option codes
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_QUICK_STOP = 16'h605A;  // Quick stop action
  localparam logic [15:0] IDX_SHUTDOWN   = 16'h605B;  // Shutdown action
  localparam logic [15:0] IDX_DISABLE    = 16'h605C;  // Disable action
  localparam logic [15:0] IDX_HALT       = 16'h605D;  // Halt action
  localparam logic [15:0] IDX_FAULT      = 16'h605E;  // Fault action

  // ----------------------------------------------------------------
  // Reset values of the option codes
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_QUICK_STOP = 16'h0001;
  localparam logic [15:0] RST_SHUTDOWN   = 16'h0001;
  localparam logic [15:0] RST_DISABLE    = 16'h0001;
  localparam logic [15:0] RST_HALT       = 16'h0001;
  localparam logic [15:0] RST_FAULT      = 16'h0002;

  // ----------------------------------------------------------------
  // Option code values
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_IMMEDIATE = 16'h0000;  // Immediate stop
  localparam logic [15:0] CODE_SLOW      = 16'h0001;  // Slow-down ramp
  localparam logic [15:0] CODE_QUICK     = 16'h0002;  // Quick stop ramp

  // ----------------------------------------------------------------
  // Event slots, also their priority order (higher slot wins)
  // ----------------------------------------------------------------
  localparam int NUM_EVT    = 5;
  localparam int SLOT_HALT  = 0;
  localparam int SLOT_DIS   = 1;
  localparam int SLOT_SHUT  = 2;
  localparam int SLOT_QS    = 3;
  localparam int SLOT_FAULT = 4;

  // Which code table a decoder applies
  typedef enum logic [2:0] {
    SRS_KIND_QS    = 3'b000,
    SRS_KIND_SHUT  = 3'b001,
    SRS_KIND_DIS   = 3'b010,
    SRS_KIND_HALT  = 3'b011,
    SRS_KIND_FAULT = 3'b100
  } srs_kind_t;

  // Ramp demanded from the motion core
  typedef enum logic [1:0] {
    SRS_RAMP_NONE  = 2'b00,
    SRS_RAMP_IMM   = 2'b01,
    SRS_RAMP_SLOW  = 2'b10,
    SRS_RAMP_QUICK = 2'b11
  } srs_ramp_t;

  // Decoded reaction of one option code
  typedef struct packed {
    logic      valid;     // Code is not reserved
    srs_ramp_t ramp;      // Stopping ramp
    logic      to_sod;    // Move to switch-on-disabled once stopped
  } srs_act_t;

  // Object dictionary request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [15:0] wdata;
  } srs_od_req_t;

  // Object dictionary answer
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } srs_od_rsp_t;

  // Events from the power state machine and control word
  typedef struct packed {
    logic fault;        // Error occurred (pulse)
    logic quick_stop;   // Entry into quick stop (pulse)
    logic shutdown;     // Operation enabled to ready to switch on (pulse)
    logic disable_op;   // Operation enabled to switched on (pulse)
    logic halt;         // Control word halt bit (level)
  } srs_evt_t;

  // Velocity mode deceleration record
  typedef struct packed {
    logic [31:0] delta_speed;
    logic [15:0] delta_time;
  } srs_decel_t;

endpackage

// ===== srs_top.sv
// Stop reaction selector: option code objects and stopping sequencer

module srs_top (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  // Object dictionary access
  input  wire srs_pkg::srs_od_req_t od_req,
  output srs_pkg::srs_od_rsp_t      od_rsp,
  // Drive events and motion status
  input  wire srs_pkg::srs_evt_t    evt,
  input  wire logic                 motor_stopped,
  input  wire logic                 vel_mode,
  input  wire srs_pkg::srs_decel_t  vl_quick_decel,
  // Stopping commands
  output srs_pkg::srs_ramp_t        ramp_cmd,
  output srs_pkg::srs_decel_t       ramp_decel,
  output logic                      ramp_use_vl,
  output logic                      sod_req,
  output logic [4:0]                code_invalid,
  output logic                      busy
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRS_ST_IDLE  = 2'b00,  // No reaction running
    SRS_ST_BRAKE = 2'b01,  // Ramp running until standstill
    SRS_ST_HALT  = 2'b10   // Halt braking, held while halt bit set
  } srs_state_t;

  logic [15:0]          code [srs_pkg::NUM_EVT];  // Option codes by slot
  srs_pkg::srs_act_t    act  [srs_pkg::NUM_EVT];  // Decoded reactions
  logic [srs_pkg::NUM_EVT-1:0] req;              // Event present per slot
  srs_state_t           state;                   // Sequencer state
  srs_state_t           next_state;
  srs_pkg::srs_ramp_t   next_ramp;
  logic                 cur_sod;                 // Running reaction ends in SOD
  logic                 next_sod;
  logic                 pick_ok;                 // A valid event was picked
  srs_pkg::srs_act_t    pick;                    // Highest priority valid reaction
  logic                 pick_halt;               // Picked reaction is the halt one

  // Maps an index to its slot; NUM_EVT when not an option code
  function automatic int unsigned slot_of(input logic [15:0] idx);
    case (idx)
      srs_pkg::IDX_HALT:       slot_of = srs_pkg::SLOT_HALT;
      srs_pkg::IDX_DISABLE:    slot_of = srs_pkg::SLOT_DIS;
      srs_pkg::IDX_SHUTDOWN:   slot_of = srs_pkg::SLOT_SHUT;
      srs_pkg::IDX_QUICK_STOP: slot_of = srs_pkg::SLOT_QS;
      srs_pkg::IDX_FAULT:      slot_of = srs_pkg::SLOT_FAULT;
      default:                 slot_of = srs_pkg::NUM_EVT;
    endcase
  endfunction

  // Slot table kinds and reset values
  localparam srs_pkg::srs_kind_t KINDS [srs_pkg::NUM_EVT] = '{
    srs_pkg::SRS_KIND_HALT, srs_pkg::SRS_KIND_DIS, srs_pkg::SRS_KIND_SHUT,
    srs_pkg::SRS_KIND_QS, srs_pkg::SRS_KIND_FAULT};
  localparam logic [15:0] RSTS [srs_pkg::NUM_EVT] = '{
    srs_pkg::RST_HALT, srs_pkg::RST_DISABLE, srs_pkg::RST_SHUTDOWN,
    srs_pkg::RST_QUICK_STOP, srs_pkg::RST_FAULT};

  assign req = {evt.fault, evt.quick_stop, evt.shutdown, evt.disable_op, evt.halt};

  // ----------------------------------------------------------------
  // Option code storage and decoding, one per event slot
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < srs_pkg::NUM_EVT; i++) begin : g_slot
      // Any value is stored; a reserved one is flagged instead of refused
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          code[i] <= RSTS[i];
        end else if (od_req.wr && slot_of(od_req.index) == i) begin
          code[i] <= od_req.wdata;
        end
      end

      srs_decode u_dec (
        .code (code[i]),
        .kind (KINDS[i]),
        .act  (act[i])
      );

      assign code_invalid[i] = !act[i].valid;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Object dictionary answer, one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      od_rsp <= '0;
    end else begin
      od_rsp.ack <= od_req.wr || od_req.rd;
      // Unknown index answers with an error and zero data
      od_rsp.err <= (od_req.wr || od_req.rd) && slot_of(od_req.index) == srs_pkg::NUM_EVT;
      if (od_req.rd && slot_of(od_req.index) != srs_pkg::NUM_EVT) begin
        od_rsp.rdata <= code[slot_of(od_req.index)];
      end else begin
        od_rsp.rdata <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Priority pick: fault, quick stop, shutdown, disable, halt
  // ----------------------------------------------------------------
  always_comb begin
    pick_ok   = 1'b0;
    pick      = '0;
    pick_halt = 1'b0;
    // Lowest slot first so the highest valid one is left standing;
    // a reserved code is skipped, so a lower event may still act
    for (int i = 0; i < srs_pkg::NUM_EVT; i++) begin
      if (req[i] && act[i].valid) begin
        pick_ok   = 1'b1;
        pick      = act[i];
        pick_halt = (i == srs_pkg::SLOT_HALT);
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_ramp  = ramp_cmd;
    next_sod   = cur_sod;
    case (state)
      SRS_ST_IDLE, SRS_ST_HALT: begin
        // Halt may be overtaken by any stronger event
        if (pick_ok && !(state == SRS_ST_HALT && pick_halt)) begin
          next_state = pick_halt ? SRS_ST_HALT : SRS_ST_BRAKE;
          next_ramp  = pick.ramp;
          next_sod   = pick.to_sod;
        end else if (state == SRS_ST_HALT && !evt.halt) begin
          // Halt released: motion resumes under the mode's control
          next_state = SRS_ST_IDLE;
          next_ramp  = srs_pkg::SRS_RAMP_NONE;
        end
      end
      SRS_ST_BRAKE: begin
        // A fault asking for a different ramp still takes over a running ramp
        if (evt.fault && act[srs_pkg::SLOT_FAULT].valid &&
            act[srs_pkg::SLOT_FAULT].ramp != ramp_cmd) begin
          next_ramp = act[srs_pkg::SLOT_FAULT].ramp;
          next_sod  = 1'b0;
        end else if (motor_stopped) begin
          next_state = SRS_ST_IDLE;
          next_ramp  = srs_pkg::SRS_RAMP_NONE;
          next_sod   = 1'b0;
        end
      end
      default: begin
        next_state = SRS_ST_IDLE;
        next_ramp  = srs_pkg::SRS_RAMP_NONE;
        next_sod   = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state    <= SRS_ST_IDLE;
      ramp_cmd <= srs_pkg::SRS_RAMP_NONE;
      cur_sod  <= 1'b0;
    end else begin
      state    <= next_state;
      ramp_cmd <= next_ramp;
      cur_sod  <= next_sod;
    end
  end

  // Switch-on-disabled request once the ramp has reached standstill
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sod_req <= 1'b0;
    end else begin
      sod_req <= state == SRS_ST_BRAKE && next_state == SRS_ST_IDLE && cur_sod;
    end
  end

  // Velocity mode quick ramp comes from its own deceleration record
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ramp_use_vl <= 1'b0;
      ramp_decel  <= '0;
    end else begin
      ramp_use_vl <= vel_mode && next_ramp == srs_pkg::SRS_RAMP_QUICK;
      ramp_decel  <= (vel_mode && next_ramp == srs_pkg::SRS_RAMP_QUICK) ?
                     vl_quick_decel : '0;
    end
  end

  assign busy = state != SRS_ST_IDLE;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Idle, one event only, and its code as given
  sequence s_only(logic bit_set, int slot, logic [15:0] val);
    state == SRS_ST_IDLE && bit_set && $onehot(req) && code[slot] == val;
  endsequence

  sequence s_sod_end;
    sod_req ##1 !sod_req && state == SRS_ST_IDLE;
  endsequence

  chk_qs_immediate_stop: assert property (@(posedge clk_sys) disable iff (reset)
    s_only(evt.quick_stop, srs_pkg::SLOT_QS, 16'h0000) |=> ramp_cmd == srs_pkg::SRS_RAMP_IMM)
    else $error("quick stop code 0 did not stop immediately");

  chk_qs_slow_sod: assert property (@(posedge clk_sys) disable iff (reset)
    s_only(evt.quick_stop, srs_pkg::SLOT_QS, 16'h0001) ##1 ramp_cmd == srs_pkg::SRS_RAMP_SLOW
      ##0 (!motor_stopped && !evt.fault) ##1 motor_stopped && !evt.fault |=> s_sod_end)
    else $error("quick stop code 1 did not end in switch-on-disabled");

  chk_qs_quick_ramp: assert property (@(posedge clk_sys) disable iff (reset)
    s_only(evt.quick_stop, srs_pkg::SLOT_QS, 16'h0002) |=>
      ramp_cmd == srs_pkg::SRS_RAMP_QUICK && busy)
    else $error("quick stop code 2 did not select the quick ramp");

  chk_shutdown_action: assert property (@(posedge clk_sys) disable iff (reset)
    s_only(evt.shutdown, srs_pkg::SLOT_SHUT, 16'h0001) |=> ramp_cmd == srs_pkg::SRS_RAMP_SLOW)
    else $error("shutdown code 1 did not select the slow ramp");

  chk_disable_action: assert property (@(posedge clk_sys) disable iff (reset)
    s_only(evt.disable_op, srs_pkg::SLOT_DIS, 16'h0000) |=> ramp_cmd == srs_pkg::SRS_RAMP_IMM)
    else $error("disable code 0 did not stop immediately");

  chk_halt_release: assert property (@(posedge clk_sys) disable iff (reset)
    s_only(evt.halt, srs_pkg::SLOT_HALT, 16'h0002) ##1 $onehot(req) && evt.halt
      ##1 req == '0 |=> state == SRS_ST_IDLE && ramp_cmd == srs_pkg::SRS_RAMP_NONE && !sod_req)
    else $error("halt braking did not follow the halt bit");

  chk_fault_ramp: assert property (@(posedge clk_sys) disable iff (reset)
    state == SRS_ST_IDLE && evt.fault && code[srs_pkg::SLOT_FAULT] == 16'h0002 |=>
      ramp_cmd == srs_pkg::SRS_RAMP_QUICK && !cur_sod)
    else $error("fault code 2 did not select the quick ramp");

  chk_vl_record_used: assert property (@(posedge clk_sys) disable iff (reset)
    ramp_cmd == srs_pkg::SRS_RAMP_QUICK && ramp_use_vl |->
      ramp_decel == $past(vl_quick_decel) && $past(vel_mode))
    else $error("velocity quick ramp did not use its record");

  chk_reserved_ignored: assert property (@(posedge clk_sys) disable iff (reset)
    state == SRS_ST_IDLE && $onehot(req) && (req & code_invalid) != '0 |=> !busy ##1 !sod_req)
    else $error("reserved option code was acted upon");

endmodule

// ===== tb_top.sv
// Self-checking bench for the stop reaction selector
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Design connections
  // ----------------------------------------------------------------
  logic                 clk_sys;         // System clock
  logic                 reset;           // Synchronous reset
  srs_pkg::srs_od_req_t od_req;          // Master request
  srs_pkg::srs_od_rsp_t od_rsp;          // Object answer
  srs_pkg::srs_evt_t    evt;             // Drive events
  logic                 motor_stopped;   // Standstill
  logic                 vel_mode;        // Velocity mode
  srs_pkg::srs_decel_t  vl_quick_decel;  // Velocity quick stop record
  srs_pkg::srs_ramp_t   ramp_cmd;        // Ramp demanded
  srs_pkg::srs_decel_t  ramp_decel;      // Record handed on
  logic                 ramp_use_vl;     // Record valid
  logic                 sod_req;         // Switch-on-disabled pulse
  logic [4:0]           code_invalid;    // Reserved code flags
  logic                 busy;            // Reaction running
  int                   error_cnt;       // Mismatches
  int                   n_compared;      // Comparisons

  // ----------------------------------------------------------------
  // Per-event tables: quick stop, shutdown, disable, halt, fault
  // ----------------------------------------------------------------
  logic [15:0] idx_of [5] = '{16'h605A, 16'h605B, 16'h605C, 16'h605D, 16'h605E};
  logic [15:0] rst_of [5] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0002};
  logic [4:0]  evt_of [5] = '{5'h08, 5'h04, 5'h02, 5'h01, 5'h10};
  int          lo_of  [5] = '{0, 0, 0, 1, 0};  // Lowest valid code
  int          hi_of  [5] = '{2, 1, 1, 2, 2};  // Highest valid code
  int          bit_of [5] = '{3, 2, 1, 0, 4};  // Flag position
  logic        sod_of [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  // Clock at 100 MHz
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  srs_top dut_u (
    .clk_sys        (clk_sys),
    .reset          (reset),
    .od_req         (od_req),
    .od_rsp         (od_rsp),
    .evt            (evt),
    .motor_stopped  (motor_stopped),
    .vel_mode       (vel_mode),
    .vl_quick_decel (vl_quick_decel),
    .ramp_cmd       (ramp_cmd),
    .ramp_decel     (ramp_decel),
    .ramp_use_vl    (ramp_use_vl),
    .sod_req        (sod_req),
    .code_invalid   (code_invalid),
    .busy           (busy)
  );

  srs_master m_u (
    .clk_sys (clk_sys),
    .od_req  (od_req),
    .od_rsp  (od_rsp)
  );

  // ----------------------------------------------------------------
  // Comparison and verdict
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Object dictionary accesses
  // ----------------------------------------------------------------
  task automatic od_wr(input int k, input logic [15:0] d);
    srs_pkg::srs_od_rsp_t rsp;
    m_u.access(1'b1, idx_of[k], d, rsp);
    chk("write ack", 48'(1'b1), 48'(rsp.ack));
    chk("write err", 48'(1'b0), 48'(rsp.err));
    chk("write data", 48'h0, 48'(rsp.rdata));
  endtask

  task automatic od_rd(input logic [15:0] idx, input logic [15:0] exp, input logic e);
    srs_pkg::srs_od_rsp_t rsp;
    m_u.access(1'b0, idx, 16'h0000, rsp);
    chk("read ack", 48'(1'b1), 48'(rsp.ack));
    chk("read err", 48'(e), 48'(rsp.err));
    chk("read data", 48'(exp), 48'(rsp.rdata));
  endtask

  // ----------------------------------------------------------------
  // One event: reaction one cycle on, end after standstill or halt drop
  // ----------------------------------------------------------------
  task automatic react(input int k, input srs_pkg::srs_ramp_t er, input logic es);
    logic ev;
    @(posedge clk_sys) evt <= srs_pkg::srs_evt_t'(evt_of[k]);
    // Halt is a level, the others last one cycle
    @(posedge clk_sys) if (k != 3) evt <= '0;
    @(posedge clk_sys);
    ev = (er == srs_pkg::SRS_RAMP_QUICK) && vel_mode;
    chk("ramp_cmd", 48'(er), 48'(ramp_cmd));
    chk("busy", 48'(er != srs_pkg::SRS_RAMP_NONE), 48'(busy));
    chk("ramp_use_vl", 48'(ev), 48'(ramp_use_vl));
    chk("ramp_decel", ev ? 48'(vl_quick_decel) : 48'h0, 48'(ramp_decel));
    evt <= '0;
    motor_stopped <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("ramp_cmd idle", 48'(srs_pkg::SRS_RAMP_NONE), 48'(ramp_cmd));
    chk("busy idle", 48'(1'b0), 48'(busy));
    chk("sod_req", 48'(es), 48'(sod_req));
    motor_stopped <= 1'b0;
    @(posedge clk_sys);
    chk("sod_req end", 48'(1'b0), 48'(sod_req));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic bad;
    error_cnt = 0;
    n_compared = 0;
    reset = 1'b1;
    evt = '0;
    motor_stopped = 1'b0;
    vel_mode = 1'b0;
    vl_quick_decel = 48'h0000_1388_0004;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    // Reset values, no reserved flags, unmapped index refused
    for (int k = 0; k < 5; k++) begin
      od_rd(idx_of[k], rst_of[k], 1'b0);
    end
    chk("code_invalid reset", 48'h0, 48'(code_invalid));
    od_rd(16'h6060, 16'h0000, 1'b1);
    $display("test reset_and_map done");
    // Every code of every event, from zero to one reserved value past the top
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_sys) vel_mode <= 1'(v);
      for (int k = 0; k < 5; k++) begin
        for (int c = 0; c <= hi_of[k] + 1; c++) begin
          bad = (c < lo_of[k]) || (c > hi_of[k]);
          od_wr(k, 16'(c));
          chk("code_invalid", 48'(bad), 48'(code_invalid[bit_of[k]]));
          od_rd(idx_of[k], 16'(c), 1'b0);
          react(k, bad ? srs_pkg::SRS_RAMP_NONE : srs_pkg::srs_ramp_t'(2'(c + 1)),
                sod_of[k] && !bad && c != 0);
        end
      end
      $display("test code_sweep pass %0d done", v);
    end
    // Negative halt code is reserved and ignored
    od_wr(3, 16'h8000);
    chk("code_invalid halt", 48'(1'b1), 48'(code_invalid[0]));
    react(3, srs_pkg::SRS_RAMP_NONE, 1'b0);
    $display("test negative_halt done");
    // Stronger events take over halt braking, then a fault takes over the ramp
    od_wr(3, 16'h0001);
    od_wr(0, 16'h0002);
    od_wr(4, 16'h0000);
    @(posedge clk_sys) evt <= 5'h01;
    repeat (2) @(posedge clk_sys);
    chk("halt ramp", 48'(srs_pkg::SRS_RAMP_SLOW), 48'(ramp_cmd));
    // Quick stop arrives while the halt bit is still set
    evt <= 5'h09;
    @(posedge clk_sys) evt <= 5'h01;
    @(posedge clk_sys);
    chk("quick stop over halt", 48'(srs_pkg::SRS_RAMP_QUICK), 48'(ramp_cmd));
    // Fault during the running ramp replaces it and drops the state change
    evt <= 5'h11;
    @(posedge clk_sys) evt <= '0;
    @(posedge clk_sys);
    chk("fault over ramp", 48'(srs_pkg::SRS_RAMP_IMM), 48'(ramp_cmd));
    motor_stopped <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("override ramp idle", 48'(srs_pkg::SRS_RAMP_NONE), 48'(ramp_cmd));
    chk("override busy", 48'(1'b0), 48'(busy));
    chk("override sod_req", 48'(1'b0), 48'(sod_req));
    motor_stopped <= 1'b0;
    // Fault and quick stop together: the fault reaction is taken
    @(posedge clk_sys) evt <= 5'h18;
    @(posedge clk_sys) evt <= '0;
    @(posedge clk_sys);
    chk("fault first", 48'(srs_pkg::SRS_RAMP_IMM), 48'(ramp_cmd));
    motor_stopped <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("fault first busy", 48'(1'b0), 48'(busy));
    chk("fault first sod_req", 48'(1'b0), 48'(sod_req));
    motor_stopped <= 1'b0;
    @(posedge clk_sys);
    $display("test override done");
    give_verdict();
  end

  // Watchdog, far beyond the roughly five hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
